//--- core/adc_timing_pkg.sv
// constants and types shared by the converter timing control
package adc_timing_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_RESULT  = 8'h04;
	localparam logic [7:0] OFS_STATUS  = 8'h08;

	// converter_control field positions
	localparam int BCS_LSB   = 14;
	localparam int STS_LSB   = 12;
	localparam int START_BIT = 0;

	// values after reset
	localparam logic [1:0]  BCS_RESET    = 2'h0;
	localparam logic [1:0]  STS_RESET    = 2'h0;
	localparam logic [9:0]  RESULT_RESET = 10'h000;
	localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;

	// status bit positions
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_CAL_BIT  = 1;

	// prescale terminal counts (divisor minus one) per basic_clock_select code
	localparam logic [3:0] DIV_M1_SEL0 = 4'h3;
	localparam logic [3:0] DIV_M1_SEL1 = 4'h1;
	localparam logic [3:0] DIV_M1_SEL2 = 4'hF;
	localparam logic [3:0] DIV_M1_SEL3 = 4'h7;

	// sample window length minus one, in basic clock periods, per sample_time_select code
	localparam logic [5:0] SAMP_M1_SEL0 = 6'h07;
	localparam logic [5:0] SAMP_M1_SEL1 = 6'h0F;
	localparam logic [5:0] SAMP_M1_SEL2 = 6'h1F;
	localparam logic [5:0] SAMP_M1_SEL3 = 6'h3F;

	// result steps, result load and calibration length
	localparam logic [5:0]  CONV_STEPS_M1  = 6'h27;
	localparam logic [1:0]  STEPS_PER_BIT_M1 = 2'h3;
	localparam logic [1:0]  LOAD_CYCLES_M1 = 2'h1;
	localparam int          CAL_BC_DEFAULT = 3328;
	localparam logic [9:0]  CODE_ZERO      = 10'h000;
	localparam logic [9:0]  CODE_FULL      = 10'h3FF;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SAMPLE  = 2'b01,
		ST_CONVERT = 2'b10,
		ST_LOAD    = 2'b11
	} conv_state_e;
endpackage

//--- core/adc_conversion_timing.sv
// timing control of the successive-approximation converter, with apb registers
// Operation
// RQ1: basic clock is cpu clock divided by 4, 2, 16 or 8 per select.
// RQ2: sample window is 8, 16, 32 or 64 basic clocks per select.
// RQ3: conversion is sample window, 40 basic clocks, then two cpu clocks load.
// RQ4: conversion length is an exact fixed count, never variable.
// RQ5: after reset a calibration of 3328 basic clocks runs.
// RQ6: conversions run during calibration and extend it by their own time.
// RQ7: input below ground reads all zeros, above reference reads all ones.
// RQ8: input is held at sample window end; later changes have no effect.
// RQ9: software keeps the basic clock between 0.5 and 6.25 MHz.
// RQ10: basic clock is an enable pulse from a prescale counter, not a clock.
module adc_conversion_timing
	import adc_timing_pkg::*;
#(
	parameter int CAL_BC_PERIODS = CAL_BC_DEFAULT
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_clk_en,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [9:0]  i_ain_code,
	input  wire logic        i_ain_below,
	input  wire logic        i_ain_above,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_track,
	output logic             o_busy,
	output logic             o_calibrating,
	output logic [9:0]       o_result
);

	if (CAL_BC_PERIODS < 1 || CAL_BC_PERIODS > 65535) begin : g_cal_check
		$error("CAL_BC_PERIODS out of range");
	end

	localparam logic [15:0] CAL_LAST = 16'(CAL_BC_PERIODS - 1);

	logic [1:0]   bcs;
	logic [1:0]   sts;
	logic [3:0]   div_m1;
	logic [5:0]   samp_m1;
	logic [3:0]   pre_cnt;
	logic         bc_tick;
	logic [5:0]   step_cnt;
	logic [1:0]   load_cnt;
	logic [15:0]  cal_cnt;
	conv_state_e  state;
	logic [9:0]   held;
	logic [9:0]   sar;
	logic [11:0]  pin_s1;
	logic [11:0]  pin_s2;
	logic [11:0]  pin_s3;
	logic [11:0]  pin_val;
	logic         held_below;
	logic         held_above;
	logic         acc;
	logic         wr_en;
	logic         start_req;
	logic [3:0]   bit_idx;
	logic [9:0]   trial;

	assign acc       = i_psel && i_penable && !o_pready;
	assign wr_en     = i_psel && i_penable && o_pready && i_pwrite;
	assign start_req = wr_en && (i_paddr == OFS_CONTROL) && i_pwdata[START_BIT]
		&& (state == ST_IDLE);
	assign bit_idx   = 4'(4'h9 - {2'b00, step_cnt[5:4] == 2'b00 ? step_cnt[3:2] : 2'b00}
		- (step_cnt[5:2] > 4'h3 ? {step_cnt[5:2]} : 4'h0));
	assign trial     = sar | (10'h001 << bit_idx);

	// control register; start bit is a self-clearing strobe
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			bcs <= BCS_RESET;
			sts <= STS_RESET;
		end else if (i_clk_en && wr_en && i_paddr == OFS_CONTROL) begin
			bcs <= i_pwdata[BCS_LSB +: 2];
			sts <= i_pwdata[STS_LSB +: 2];
		end
	end

	// timing is frozen per conversion so a field write mid-run cannot stretch it
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			div_m1  <= DIV_M1_SEL0;
			samp_m1 <= SAMP_M1_SEL0;
		end else if (i_clk_en && state == ST_IDLE) begin
			case (bcs) // RQ1
				2'b00: div_m1 <= DIV_M1_SEL0;
				2'b01: div_m1 <= DIV_M1_SEL1;
				2'b10: div_m1 <= DIV_M1_SEL2;
				default: div_m1 <= DIV_M1_SEL3;
			endcase
			case (sts) // RQ2
				2'b00: samp_m1 <= SAMP_M1_SEL0;
				2'b01: samp_m1 <= SAMP_M1_SEL1;
				2'b10: samp_m1 <= SAMP_M1_SEL2;
				default: samp_m1 <= SAMP_M1_SEL3;
			endcase
		end
	end

	// prescaler restarts on start so every conversion has the same length
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			pre_cnt <= 4'h0;
			bc_tick <= 1'b0;
		end else if (i_clk_en) begin
			// start edge is the first prescale cycle, else the first period runs one long
			if (start_req) begin // RQ4
				pre_cnt <= 4'h1;
				bc_tick <= 1'b0;
			end else if (pre_cnt == div_m1) begin // RQ10
				pre_cnt <= 4'h0;
				bc_tick <= 1'b1;
			end else begin
				pre_cnt <= 4'(pre_cnt + 4'h1);
				bc_tick <= 1'b0;
			end
		end
	end

	// analog side inputs: three stages, accepted when the last two agree
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			pin_s1  <= 12'h000;
			pin_s2  <= 12'h000;
			pin_s3  <= 12'h000;
			pin_val <= 12'h000;
		end else if (i_clk_en) begin
			pin_s1 <= {i_ain_above, i_ain_below, i_ain_code};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			if (pin_s2 == pin_s3) begin
				pin_val <= pin_s3;
			end
		end
	end

	// conversion sequencer
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state    <= ST_IDLE;
			step_cnt <= 6'h00;
			load_cnt <= 2'h0;
		end else if (i_clk_en) begin
			case (state)
				ST_IDLE: begin
					if (start_req) begin // RQ6
						state    <= ST_SAMPLE;
						step_cnt <= 6'h00;
					end
				end
				ST_SAMPLE: begin
					if (bc_tick) begin
						if (step_cnt == samp_m1) begin // RQ2
							state    <= ST_CONVERT;
							step_cnt <= 6'h00;
						end else begin
							step_cnt <= 6'(step_cnt + 6'h01);
						end
					end
				end
				ST_CONVERT: begin
					if (bc_tick) begin
						if (step_cnt == CONV_STEPS_M1) begin // RQ3
							state    <= ST_LOAD;
							load_cnt <= 2'h0;
						end else begin
							step_cnt <= 6'(step_cnt + 6'h01);
						end
					end
				end
				ST_LOAD: begin
					if (load_cnt == LOAD_CYCLES_M1) begin // RQ3
						state <= ST_IDLE;
					end else begin
						load_cnt <= 2'(load_cnt + 2'h1);
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// hold the input when the sample window closes
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			held       <= CODE_ZERO;
			held_below <= 1'b0;
			held_above <= 1'b0;
		end else if (i_clk_en && state == ST_SAMPLE && bc_tick && step_cnt == samp_m1) begin
			held       <= pin_val[9:0]; // RQ8
			held_below <= pin_val[10];
			held_above <= pin_val[11];
		end
	end

	// one result bit per four basic clocks, msb first
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			sar <= CODE_ZERO;
		end else if (i_clk_en) begin
			if (state == ST_SAMPLE) begin
				sar <= CODE_ZERO;
			end else if (state == ST_CONVERT && bc_tick && step_cnt[1:0] == STEPS_PER_BIT_M1) begin
				if (trial <= held) begin
					sar <= trial;
				end
			end
		end
	end

	// result register loaded in the second load cycle
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_result <= RESULT_RESET;
		end else if (i_clk_en && state == ST_LOAD && load_cnt == LOAD_CYCLES_M1) begin
			if (held_below) begin // RQ7
				o_result <= CODE_ZERO;
			end else if (held_above) begin // RQ7
				o_result <= CODE_FULL;
			end else begin
				o_result <= sar;
			end
		end
	end

	// calibration only counts while idle, so conversions lengthen it
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			cal_cnt       <= 16'h0000;
			o_calibrating <= 1'b1;
		end else if (i_clk_en && o_calibrating && state == ST_IDLE && !start_req && bc_tick) begin
			if (cal_cnt == CAL_LAST) begin // RQ5
				o_calibrating <= 1'b0;
			end else begin
				cal_cnt <= 16'(cal_cnt + 16'h0001); // RQ6
			end
		end
	end

	// status pins
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_busy  <= 1'b0;
			o_track <= 1'b0;
		end else if (i_clk_en) begin
			o_busy  <= start_req || (state != ST_IDLE && !(state == ST_LOAD
				&& load_cnt == LOAD_CYCLES_M1));
			o_track <= start_req || (state == ST_SAMPLE && !(bc_tick && step_cnt == samp_m1));
		end
	end

	// apb slave: one wait state, read data and error come with pready
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= RDATA_RESET;
		end else if (i_clk_en) begin
			o_pready  <= acc;
			o_pslverr <= 1'b0;
			o_prdata  <= RDATA_RESET;
			if (acc) begin
				if (i_paddr == OFS_CONTROL) begin
					o_prdata[BCS_LSB +: 2] <= bcs;
					o_prdata[STS_LSB +: 2] <= sts;
				end else if (i_paddr == OFS_RESULT) begin
					o_prdata[9:0] <= o_result;
				end else if (i_paddr == OFS_STATUS) begin
					o_prdata[STAT_BUSY_BIT] <= o_busy;
					o_prdata[STAT_CAL_BIT]  <= o_calibrating;
				end else begin
					o_pslverr <= 1'b1;
				end
			end
		end
	end

endmodule

//--- tb/adc_ain_model.sv
// analog source model feeding the converter input image
module adc_ain_model (
	input  wire logic       i_ref_clk,
	input  wire logic       i_track,
	input  wire logic [9:0] i_level,
	input  wire logic       i_low,
	input  wire logic       i_high,
	output logic      [9:0] o_code = 10'h000,
	output logic            o_below = 1'b0,
	output logic            o_above = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// outside the window the source wanders, so a missing hold shows
	always @(posedge i_ref_clk) begin
		o_code <= i_track ? i_level : ~i_level;
		o_below <= i_track ? i_low : ~i_low;
		o_above <= i_track ? i_high : ~i_high;
	end
endmodule

//--- tb/adc_conversion_timing_chk.sv
// port assertions for the converter timing control
module adc_conversion_timing_chk #(
	parameter int CAL_BC_PERIODS = 3328
) (
	input wire logic        i_ref_clk,
	input wire logic        i_rst_n,
	input wire logic        i_clk_en,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [9:0]  i_ain_code,
	input wire logic        i_ain_below,
	input wire logic        i_ain_above,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_track,
	input wire logic        o_busy,
	input wire logic        o_calibrating,
	input wire logic [9:0]  o_result
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	logic [11:0] busy_len;
	always_ff @(posedge i_ref_clk) begin
		// enabled edges only, so a frozen clock does not stretch the count
		if (!i_rst_n || !o_busy)
			busy_len <= 12'h000;
		else if (i_clk_en)
			busy_len <= busy_len + 12'h001;
	end
	chk_track_opens: assert property ($rose(o_busy) |-> o_track)
		else $error("window not open at start");
	chk_window_min: assert property ($rose(o_track) |-> o_track[*8])
		else $error("sample window too short");
	chk_convert_min: assert property ($fell(o_track) |-> o_busy[*8])
		else $error("result steps cut short");
	chk_idle_shut: assert property (!o_busy |-> !o_track)
		else $error("window open while idle");
	chk_result_moves: assert property ($changed(o_result) |-> $fell(o_busy))
		else $error("result changed outside load");
	chk_busy_span: assert property ($fell(o_busy) |-> busy_len >= 12'h062 && busy_len <= 12'h682)
		else $error("conversion length out of range");
	chk_cal_start: assert property ($rose(i_rst_n) |-> o_calibrating)
		else $error("calibration not running after reset");
	chk_cal_once: assert property (!o_calibrating |=> !o_calibrating)
		else $error("calibration restarted");
endmodule

bind adc_conversion_timing adc_conversion_timing_chk #(.CAL_BC_PERIODS(CAL_BC_PERIODS)) u_chk (
	.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.i_ain_code(i_ain_code), .i_ain_below(i_ain_below), .i_ain_above(i_ain_above),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_track(o_track),
	.o_busy(o_busy), .o_calibrating(o_calibrating), .o_result(o_result));

//--- tb/adc_conversion_timing_tb.sv
// self-checking bench for the converter timing control
module adc_conversion_timing_tb;
	import adc_timing_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        clk_en = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [9:0]  level = 10'h000;
	logic        low = 1'b0;
	logic        high = 1'b0;
	logic [9:0]  code;
	logic [9:0]  res;
	logic        below, above, track, busy, cal, pready, pslverr, err;
	logic [31:0] prdata, rd;
	int          failures = 0;
	int          checks = 0;
	int          n;
	int          dv[4] = '{4, 2, 16, 8};
	logic [9:0]  lvs[4] = '{10'h2A5, 10'h0C3, 10'h3C0, 10'h15A};
	logic [9:0]  exps[4] = '{10'h2A5, 10'h000, 10'h3FF, 10'h15A};
	logic [3:0]  lo_set = 4'h2;
	logic [3:0]  hi_set = 4'h4;
	always #25 clk = ~clk;
	adc_conversion_timing #(.CAL_BC_PERIODS(8)) u_dut (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_ain_code(code), .i_ain_below(below), .i_ain_above(above), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_track(track), .o_busy(busy),
		.o_calibrating(cal), .o_result(res));
	adc_ain_model u_src (.i_ref_clk(clk), .i_track(track), .i_level(level), .i_low(low),
		.i_high(high), .o_code(code), .o_below(below), .o_above(above));
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// one idle edge first so a strobe is never dropped and raised in one step
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic conv(input int s);
		logic [31:0] ctl;
		logic        half;
		int          e;
		ctl = (32'(s) << BCS_LSB) | (32'(s) << STS_LSB);
		// divide by 2 runs at half cpu rate so the basic clock stays in range
		half = (s == 1);
		e = ((8 << s) + 40) * dv[s] + 2;
		level <= lvs[s];
		low <= lo_set[s];
		high <= hi_set[s];
		bus(1'b1, OFS_CONTROL, ctl);
		bus(1'b1, OFS_CONTROL, ctl | 32'h0000_0001);
		n = 0;
		do begin
			@(posedge clk);
			n++;
			clk_en <= !half || ((n % 2) == 0);
		end while ((n < 3 || busy !== 1'b0) && n < 3000);
		check(32'(n), half ? 32'(2 * e) : 32'(e + 1), "conversion length");
		check({22'h0, res}, {22'h0, exps[s]}, "result port");
		bus(1'b0, OFS_RESULT, 32'h0000_0000);
		check(rd, {22'h0, exps[s]}, "result register");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		tally_and_finish();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, OFS_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0002, "status after reset");
		check({31'h0, cal}, 32'h0000_0001, "calibrating port set");
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			conv(i);
			if (i == 0) begin
				bus(1'b0, OFS_STATUS, 32'h0000_0000);
				check(rd, 32'h0000_0002, "calibration paused");
			end
			$display("test conversion %0d done", i);
		end
		bus(1'b0, 8'h0C, 32'h0000_0000);
		check({31'h0, err}, 32'h0000_0001, "unmapped error");
		check(rd, 32'h0000_0000, "unmapped data");
		repeat (200) @(posedge clk);
		bus(1'b0, OFS_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0000, "calibration over");
		check({31'h0, cal}, 32'h0000_0000, "calibrating port clear");
		$display("test calibration done");
		tally_and_finish();
	end
endmodule
